/* File: sim/dmmp_parser_model.sv */
// Behavioural payload parser that sinks the producer's bit stream
module dmmp_parser_model (
    input  wire logic ref_clk_i,
    input  wire logic bit_i,
    input  wire logic valid_i,
    input  wire logic first_i,
    input  wire logic last_i,
    input  wire logic slow_i,
    output logic      ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       q[$];
    logic [1:0] cyc = 2'h0;
    int         p, nbits, npay, hn, bad, wt, gain, len, lvl, ubase, cnt;
    int         hl[8];
    int         hv[8];
    // Stalls three cycles of four when slow
    assign ready_o = !slow_i || cyc == 2'h0;
    always_ff @(posedge ref_clk_i) cyc <= cyc + 2'h1;
    function automatic int rd(int n);
        int v = 0;
        repeat (n) begin
            v = (v << 1) | int'(q[p] === 1'b1);
            p++;
        end
        return v;
    endfunction
    function automatic int ue();
        int z = 0;
        while (q[p] === 1'b0 && z < 24) begin
            z++;
            p++;
        end
        p++;
        return (1 << z) - 1 + rd(z);
    endfunction
    // zero pad bits up to a bit position
    task automatic pad(int upto);
        while (p < upto) bad += rd(1);
    endtask
    task automatic parse();
        p = 0;
        bad = int'(ue() != 1);
        bad += int'(ue() != 0);
        // refresh drops held blocks, otherwise they persist
        if (rd(1) == 1) begin
            hn = 0;
            gain = 2048;
            cnt = ue();
            if (cnt != 0) pad((p + 7) / 8 * 8);
            repeat (cnt) begin
                len = ue();
                lvl = rd(8);
                ubase = p;
                hl[hn] = lvl;
                case (lvl)
                    1: begin
                        hv[hn] = rd(12);
                        p += 24;
                    end
                    2: begin
                        hv[hn] = rd(12);
                        gain = rd(12);
                        p += 48;
                        wt = rd(13);
                    end
                    5: begin
                        hv[hn] = rd(13);
                        p += 39;
                    end
                    default: hv[hn] = 0;
                endcase
                if (lvl inside {1, 2, 5} && hn < 7) hn++;
                bad += int'(p > ubase + 8 * len);
                pad(ubase + 8 * len);
            end
        end
        pad((p + 7) / 8 * 8);
        bad += int'(p != q.size());
    endtask
    always @(posedge ref_clk_i) begin
        if (valid_i && ready_o) begin
            if (first_i) q.delete();
            q.push_back(bit_i);
            if (last_i) begin
                parse();
                nbits = q.size();
                npay++;
            end
        end
    end
endmodule : dmmp_parser_model

/* File: sim/dmmp_producer_tb_top.sv */
// Testbench for the metadata payload producer
module dmmp_producer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        bit_o;
    logic        bit_valid_o;
    logic        bit_first_o;
    logic        bit_last_o;
    logic        bit_ready_i;
    logic        slow = 1'b0;
    logic [31:0] rdat;
    int          error_cnt = 0;
    int          tests_run = 0;
    // Bad lists: count, then levels of blocks 0 to 3
    logic [39:0] bad_list [7] = '{40'h0001020102, 40'h0501050105, 40'h0205010000,
                                  40'h0301050500, 40'h0301050200, 40'h0202020000,
                                  40'h0103000000};
    dmmp_producer #(.MAX_BLOCKS(4)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .bit_o(bit_o), .bit_valid_o(bit_valid_o), .bit_first_o(bit_first_o),
        .bit_last_o(bit_last_o), .bit_ready_i(bit_ready_i));
    dmmp_parser_model pm (.ref_clk_i(ref_clk_i), .bit_i(bit_o), .valid_i(bit_valid_o),
        .first_i(bit_first_o), .last_i(bit_last_o), .slow_i(slow), .ready_o(bit_ready_i));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    task automatic wrap_up();
        $display("Counts: error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        rdat = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            error_cnt++;
            wrap_up();
        end
    endtask : bus
    task automatic blk(int i, logic [7:0] l, logic [31:0] f0, logic [31:0] f1, logic [31:0] f2);
        bus(1'b1, dmmp_pkg::ADDR_SEL, i);
        bus(1'b1, dmmp_pkg::ADDR_LEVEL, {24'h0, l});
        bus(1'b1, dmmp_pkg::ADDR_F0, f0);
        bus(1'b1, dmmp_pkg::ADDR_F1, f1);
        bus(1'b1, dmmp_pkg::ADDR_F2, f2);
    endtask : blk
    task automatic go(logic rf, int np);
        int n = 0;
        bus(1'b1, dmmp_pkg::ADDR_CTRL, 32'h1 | (32'(rf) << dmmp_pkg::CTRL_REFRESH));
        while (pm.npay != np && n < 4000) begin
            n++;
            @(posedge ref_clk_i);
        end
        if (n == 4000) begin
            error_cnt++;
            wrap_up();
        end
    endtask : go
    task automatic s_idle();
        bus(1'b0, dmmp_pkg::ADDR_STATUS, 32'h0);
        chk(rdat, 32'h0);
        bus(1'b0, dmmp_pkg::ADDR_CTRL, 32'h0);
        chk(rdat, 32'(dmmp_pkg::REFRESH_RST) << dmmp_pkg::CTRL_REFRESH);
        bus(1'b0, 4'hf, 32'h0);
        chk(rdat, 32'h0);
    endtask : s_idle
    task automatic s_plain();
        go(1'b0, 1);
        chk(pm.bad, 0);
        chk(pm.nbits, 8);
        bus(1'b0, dmmp_pkg::ADDR_BITS, 32'h0);
        chk(rdat, 8);
    endtask : s_plain
    task automatic s_list();
        bus(1'b1, dmmp_pkg::ADDR_COUNT, 4);
        blk(0, 8'h01, 32'h23fed456, 32'h1, 32'h0);
        blk(1, 8'h05, 32'h0, 32'h000d5e00, 32'h0);
        blk(2, 8'h02, 32'h0, 32'h0, 32'h000f4a00);
        blk(3, 8'h05, 32'h0, 32'h00000380, 32'h0);
        slow <= 1'b1;
        go(1'b1, 2);
        slow <= 1'b0;
        chk(pm.bad, 0);
        chk(pm.nbits, 320);
        chk(pm.hn, 4);
        chk({pm.hl[0][7:0], pm.hl[1][7:0], pm.hl[2][7:0], pm.hl[3][7:0]}, 32'h01050205);
        chk({pm.hv[0][15:0], pm.hv[1][15:0]}, 32'h01231abc);
        chk({pm.hv[2][15:0], pm.hv[3][15:0]}, 32'h07a50007);
        chk(pm.wt, dmmp_pkg::WEIGHT_RSVD);
        go(1'b0, 3);
        chk(pm.hn, 4);
        bus(1'b1, dmmp_pkg::ADDR_COUNT, 2);
        go(1'b1, 4);
        chk(pm.hn, 2);
        chk(pm.gain, 2048);
        chk(pm.nbits, 136);
    endtask : s_list
    task automatic s_refuse();
        for (int k = 0; k < 7; k++) begin
            bus(1'b1, dmmp_pkg::ADDR_COUNT, bad_list[k][39:32]);
            for (int i = 0; i < 4; i++) blk(i, bad_list[k][31-8*i -: 8], 0, 0, 32'h400);
            go(1'b1, 4);
            repeat (20) @(posedge ref_clk_i);
            bus(1'b0, dmmp_pkg::ADDR_STATUS, 32'h0);
            chk(rdat & 32'h3, 32'h1 << dmmp_pkg::STAT_ERR);
            chk(pm.npay, 4);
            bus(1'b1, dmmp_pkg::ADDR_CTRL, 32'h1 << dmmp_pkg::CTRL_CLEAR);
        end
    endtask : s_refuse
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        s_idle();
        s_plain();
        s_list();
        s_refuse();
        wrap_up();
    end
endmodule : dmmp_producer_tb_top

/* File: src/dmmp_pkg.sv */
// Constants and types for the display mapping metadata producer
package dmmp_pkg;
    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_STATUS   = 4'h1;
    localparam logic [3:0]  ADDR_COUNT    = 4'h2;
    localparam logic [3:0]  ADDR_SEL      = 4'h3;
    localparam logic [3:0]  ADDR_LEVEL    = 4'h4;
    localparam logic [3:0]  ADDR_F0       = 4'h5;
    localparam logic [3:0]  ADDR_F1       = 4'h6;
    localparam logic [3:0]  ADDR_F2       = 4'h7;
    localparam logic [3:0]  ADDR_BITS     = 4'h8;
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_REFRESH  = 1;
    localparam int          CTRL_CLEAR    = 2;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_ERR      = 1;
    localparam logic        REFRESH_RST   = 1'b0;
    localparam logic [10:0] APP_ID        = 11'h001;
    localparam logic [10:0] APP_VER       = 11'h000;
    localparam logic [7:0]  LVL_RANGE     = 8'h01;
    localparam logic [7:0]  LVL_TRIM      = 8'h02;
    localparam logic [7:0]  LVL_AREA      = 8'h05;
    localparam logic [9:0]  BYTES_RANGE   = 10'h005;
    localparam logic [9:0]  BYTES_TRIM    = 10'h00b;
    localparam logic [9:0]  BYTES_AREA    = 10'h007;
    localparam logic [6:0]  USE_RANGE     = 7'h24;
    localparam logic [6:0]  USE_TRIM      = 7'h55;
    localparam logic [6:0]  USE_AREA      = 7'h34;
    localparam logic [12:0] WEIGHT_RSVD   = 13'h1fff;
    localparam logic [7:0]  CNT_MIN       = 8'h01;
    localparam logic [7:0]  CNT_MAX       = 8'hfe;
    localparam int          EM_W          = 96;
    localparam int          PEAK_LSB      = 73;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ID   = 4'h1,
        ST_VER  = 4'h2,
        ST_REF  = 4'h3,
        ST_CNT  = 4'h4,
        ST_AL1  = 4'h5,
        ST_LEN  = 4'h6,
        ST_LVL  = 4'h7,
        ST_PAY  = 4'h8,
        ST_AL2  = 4'h9
    } dmmp_state_t;
endpackage : dmmp_pkg

/* File: src/dmmp_producer.sv */
// Metadata payload bit producer with Avalon-MM control registers
// Function
// - Application identifier is sent as Exp-Golomb value one.
// - Application version is sent as Exp-Golomb value zero.
// - Block count is 1 to 254, zero pad to byte before first block.
// - Each block: Exp-Golomb byte length 0 to 1023, 8-bit level, payload.
// - Reserved levels are never sent; parser would skip them.
// - Byte lengths are 5 for range, 11 for trim, 7 for area.
// - An area block needs an earlier range or trim block.
// - Two area blocks need a range or trim block between them.
// - No range or trim block follows the last area block.
// - Every 12-bit luma code stays within 0 to 4095.
// - Reserved signed weight is sent as all ones.
// - Several trim blocks carry distinct target peak codes.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
module dmmp_producer #(
    parameter int MAX_BLOCKS = 8
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Payload bit stream
    output logic             bit_o,
    output logic             bit_valid_o,
    output logic             bit_first_o,
    output logic             bit_last_o,
    input  wire logic        bit_ready_i
);
    localparam int IW = (MAX_BLOCKS > 1) ? $clog2(MAX_BLOCKS) : 1;

    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[8*b +: 8] = n[8*b +: 8];
        end
        return r;
    endfunction : be_merge

    function automatic logic [6:0] ue_len(input logic [10:0] v);
        logic [11:0] c;
        logic [6:0]  n;
        c = {1'b0, v} + 12'h001;
        n = 7'h01;
        for (int k = 1; k < 12; k++) begin
            if (c[k]) n = 7'(2 * k + 1);
        end
        return n;
    endfunction : ue_len

    function automatic logic [9:0] blk_bytes(input logic [7:0] l);
        case (l)
            dmmp_pkg::LVL_RANGE: blk_bytes = dmmp_pkg::BYTES_RANGE;
            dmmp_pkg::LVL_TRIM:  blk_bytes = dmmp_pkg::BYTES_TRIM;
            default:             blk_bytes = dmmp_pkg::BYTES_AREA;
        endcase
    endfunction : blk_bytes

    function automatic logic [6:0] blk_use(input logic [7:0] l);
        case (l)
            dmmp_pkg::LVL_RANGE: blk_use = dmmp_pkg::USE_RANGE;
            dmmp_pkg::LVL_TRIM:  blk_use = dmmp_pkg::USE_TRIM;
            default:             blk_use = dmmp_pkg::USE_AREA;
        endcase
    endfunction : blk_use

    function automatic logic lvl_known(input logic [7:0] l);
        return l == dmmp_pkg::LVL_RANGE || l == dmmp_pkg::LVL_TRIM ||
               l == dmmp_pkg::LVL_AREA;
    endfunction : lvl_known

    // Register file and block store
    logic        ack_q;
    logic [31:0] rd_q;
    logic        refresh_q;
    logic        err_q;
    logic [7:0]  cnt_q;
    logic [7:0]  sel_q;
    logic [15:0] bits_q;
    logic [7:0]  lvl_q [MAX_BLOCKS];
    logic [95:0] pay_q [MAX_BLOCKS];
    dmmp_pkg::dmmp_state_t st_q, nst;
    logic [95:0] em_q;
    logic [6:0]  emc_q;
    logic [2:0]  pos_q;
    logic [7:0]  idx_q;
    logic        first_q;

    logic        acc, wr, start_wr, busy, ok, go, fire, adv, ld, step, fin, tail;
    logic        sel_ok;
    logic [95:0] nval;
    logic [6:0]  nlen;
    logic [7:0]  nidx, cur_lvl, nxt_lvl;
    logic [2:0]  pos_n;
    logic [95:0] cur_pay;

    assign acc      = (avs_read_i | avs_write_i) & ~ack_q;
    assign wr       = avs_write_i & ack_q;
    assign busy     = st_q != dmmp_pkg::ST_IDLE;
    assign sel_ok   = sel_q < 8'(MAX_BLOCKS);
    assign start_wr = wr && avs_address_i == dmmp_pkg::ADDR_CTRL && avs_byteenable_i[0] &&
                      avs_writedata_i[dmmp_pkg::CTRL_START] && !busy;
    assign go       = start_wr & ok;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o    = rd_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ack_q <= 1'b0;
        else ack_q <= acc;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 32'h0;
        end else if (acc && avs_read_i) begin
            case (avs_address_i)
                dmmp_pkg::ADDR_CTRL:   rd_q <= {30'h0, refresh_q, 1'b0};
                dmmp_pkg::ADDR_STATUS: rd_q <= {30'h0, err_q, busy};
                dmmp_pkg::ADDR_COUNT:  rd_q <= {24'h0, cnt_q};
                dmmp_pkg::ADDR_SEL:    rd_q <= {24'h0, sel_q};
                dmmp_pkg::ADDR_LEVEL:  rd_q <= sel_ok ? {24'h0, lvl_q[sel_q[IW-1:0]]} : 32'h0;
                dmmp_pkg::ADDR_F0:     rd_q <= sel_ok ? pay_q[sel_q[IW-1:0]][31:0] : 32'h0;
                dmmp_pkg::ADDR_F1:     rd_q <= sel_ok ? pay_q[sel_q[IW-1:0]][63:32] : 32'h0;
                dmmp_pkg::ADDR_F2:     rd_q <= sel_ok ? pay_q[sel_q[IW-1:0]][95:64] : 32'h0;
                dmmp_pkg::ADDR_BITS:   rd_q <= {16'h0, bits_q};
                default:               rd_q <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            refresh_q <= dmmp_pkg::REFRESH_RST;
            cnt_q     <= 8'h00;
            sel_q     <= 8'h00;
        end else if (wr && !busy) begin
            if (avs_address_i == dmmp_pkg::ADDR_CTRL && avs_byteenable_i[0])
                refresh_q <= avs_writedata_i[dmmp_pkg::CTRL_REFRESH];
            if (avs_address_i == dmmp_pkg::ADDR_COUNT && avs_byteenable_i[0])
                cnt_q <= avs_writedata_i[7:0];
            if (avs_address_i == dmmp_pkg::ADDR_SEL && avs_byteenable_i[0])
                sel_q <= avs_writedata_i[7:0];
        end
    end

    // Block store is frozen while a payload is being sent
    always_ff @(posedge ref_clk_i) begin
        if (wr && !busy && sel_ok) begin
            if (avs_address_i == dmmp_pkg::ADDR_LEVEL && avs_byteenable_i[0])
                lvl_q[sel_q[IW-1:0]] <= avs_writedata_i[7:0];
            if (avs_address_i == dmmp_pkg::ADDR_F0)
                pay_q[sel_q[IW-1:0]][31:0] <= be_merge(pay_q[sel_q[IW-1:0]][31:0],
                                                      avs_writedata_i, avs_byteenable_i);
            if (avs_address_i == dmmp_pkg::ADDR_F1)
                pay_q[sel_q[IW-1:0]][63:32] <= be_merge(pay_q[sel_q[IW-1:0]][63:32],
                                                       avs_writedata_i, avs_byteenable_i);
            if (avs_address_i == dmmp_pkg::ADDR_F2)
                pay_q[sel_q[IW-1:0]][95:64] <= be_merge(pay_q[sel_q[IW-1:0]][95:64],
                                                       avs_writedata_i, avs_byteenable_i);
        end
    end

    // Error flag: refused start sets it, set wins over clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) err_q <= 1'b0;
        else if (start_wr && !ok) err_q <= 1'b1;
        else if (wr && avs_address_i == dmmp_pkg::ADDR_CTRL && avs_byteenable_i[0] &&
                 avs_writedata_i[dmmp_pkg::CTRL_CLEAR]) err_q <= 1'b0;
    end

    // Block list check before a refresh payload is started
    always_comb begin
        logic seen, any5;
        seen = 1'b0;
        any5 = 1'b0;
        ok   = 1'b1;
        if (avs_writedata_i[dmmp_pkg::CTRL_REFRESH]) begin
            if (cnt_q < dmmp_pkg::CNT_MIN || cnt_q > dmmp_pkg::CNT_MAX ||
                cnt_q > 8'(MAX_BLOCKS)) ok = 1'b0;
            for (int i = 0; i < MAX_BLOCKS; i++) begin
                if (8'(i) < cnt_q) begin
                    if (!lvl_known(lvl_q[i])) ok = 1'b0;
                    if (lvl_q[i] == dmmp_pkg::LVL_AREA) begin
                        if (!seen) ok = 1'b0;
                        seen = 1'b0;
                        any5 = 1'b1;
                    end else begin
                        seen = 1'b1;
                    end
                    for (int j = 0; j < i; j++) begin
                        if (lvl_q[i] == dmmp_pkg::LVL_TRIM && lvl_q[j] == dmmp_pkg::LVL_TRIM &&
                            pay_q[i][dmmp_pkg::PEAK_LSB +: 12] ==
                            pay_q[j][dmmp_pkg::PEAK_LSB +: 12]) ok = 1'b0;
                    end
                end
            end
            if (any5 && seen) ok = 1'b0;
        end
    end

    assign bit_valid_o = busy;
    assign fire        = busy & bit_ready_i;
    assign adv         = emc_q == 7'h01;
    assign bit_o       = em_q[dmmp_pkg::EM_W-1];
    assign bit_first_o = busy & first_q;
    assign bit_last_o  = busy & fin;

    // Payload of the current block, masked, weight forced, padded to bytes
    always_comb begin
        logic [6:0] u;
        logic [6:0] padn;
        cur_lvl = lvl_q[idx_q[IW-1:0]];
        u       = blk_use(cur_lvl);
        padn    = 7'({blk_bytes(cur_lvl), 3'b000} - {6'h00, u});
        cur_pay = pay_q[idx_q[IW-1:0]] & ({96{1'b1}} >> (7'(dmmp_pkg::EM_W) - u));
        if (cur_lvl == dmmp_pkg::LVL_TRIM) cur_pay[12:0] = dmmp_pkg::WEIGHT_RSVD;
        cur_pay = cur_pay << padn;
    end

    // Next field selection at the last bit of each field
    always_comb begin
        nst     = st_q;
        nval    = '0;
        nlen    = 7'h01;
        step    = 1'b0;
        fin     = 1'b0;
        tail    = 1'b0;
        nidx    = idx_q + 8'h01;
        nxt_lvl = lvl_q[nidx[IW-1:0]];
        pos_n   = pos_q + 3'h1;
        if (!busy) begin
            nst  = dmmp_pkg::ST_ID;
            nval = 96'({1'b0, dmmp_pkg::APP_ID} + 12'h001);
            nlen = ue_len(dmmp_pkg::APP_ID);
        end else if (adv) begin
            case (st_q)
                dmmp_pkg::ST_ID: begin
                    nst  = dmmp_pkg::ST_VER;
                    nval = 96'({1'b0, dmmp_pkg::APP_VER} + 12'h001);
                    nlen = ue_len(dmmp_pkg::APP_VER);
                end
                dmmp_pkg::ST_VER: begin
                    nst  = dmmp_pkg::ST_REF;
                    nval = 96'(refresh_q);
                end
                dmmp_pkg::ST_REF: begin
                    if (refresh_q) begin
                        nst  = dmmp_pkg::ST_CNT;
                        nval = 96'({4'h0, cnt_q} + 12'h001);
                        nlen = ue_len({3'h0, cnt_q});
                    end else begin
                        tail = 1'b1;
                    end
                end
                dmmp_pkg::ST_CNT, dmmp_pkg::ST_AL1: begin
                    if (pos_n == 3'h0) begin
                        nst  = dmmp_pkg::ST_LEN;
                        nval = 96'({2'h0, blk_bytes(cur_lvl)} + 12'h001);
                        nlen = ue_len({1'b0, blk_bytes(cur_lvl)});
                    end else begin
                        nst = dmmp_pkg::ST_AL1;
                    end
                end
                dmmp_pkg::ST_LEN: begin
                    nst  = dmmp_pkg::ST_LVL;
                    nval = 96'(cur_lvl);
                    nlen = 7'h08;
                end
                dmmp_pkg::ST_LVL: begin
                    nst  = dmmp_pkg::ST_PAY;
                    nval = cur_pay;
                    nlen = 7'({blk_bytes(cur_lvl), 3'b000});
                end
                dmmp_pkg::ST_PAY: begin
                    step = 1'b1;
                    if (nidx < cnt_q) begin
                        nst  = dmmp_pkg::ST_LEN;
                        nval = 96'({2'h0, blk_bytes(nxt_lvl)} + 12'h001);
                        nlen = ue_len({1'b0, blk_bytes(nxt_lvl)});
                    end else begin
                        tail = 1'b1;
                    end
                end
                dmmp_pkg::ST_AL2: tail = 1'b1;
                default: nst = dmmp_pkg::ST_IDLE;
            endcase
            if (tail) begin
                if (pos_n == 3'h0) begin
                    nst = dmmp_pkg::ST_IDLE;
                    fin = 1'b1;
                end else begin
                    nst = dmmp_pkg::ST_AL2;
                end
            end
        end
    end

    assign ld = busy ? (fire & adv) : go;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) st_q <= dmmp_pkg::ST_IDLE;
        else if (ld) st_q <= nst;
    end

    // Left-aligned shifter, first bit sent is the field's top bit
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            em_q  <= '0;
            emc_q <= 7'h00;
        end else if (ld) begin
            em_q  <= nval << (7'(dmmp_pkg::EM_W) - nlen);
            emc_q <= nlen;
        end else if (fire) begin
            em_q  <= {em_q[dmmp_pkg::EM_W-2:0], 1'b0};
            emc_q <= emc_q - 7'h01;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_q   <= 3'h0;
            idx_q   <= 8'h00;
            bits_q  <= 16'h0;
            first_q <= 1'b0;
        end else if (go) begin
            pos_q   <= 3'h0;
            idx_q   <= 8'h00;
            bits_q  <= 16'h0;
            first_q <= 1'b1;
        end else if (fire) begin
            pos_q   <= pos_n;
            bits_q  <= bits_q + 16'h1;
            first_q <= 1'b0;
            if (adv && step) idx_q <= nidx;
        end
    end

    // Helper for ordering checks on what is actually sent
    logic seen_q, any5_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_q <= 1'b0;
            any5_q <= 1'b0;
        end else if (go) begin
            seen_q <= 1'b0;
            any5_q <= 1'b0;
        end else if (fire && adv && st_q == dmmp_pkg::ST_LVL) begin
            seen_q <= cur_lvl != dmmp_pkg::LVL_AREA;
            any5_q <= any5_q | (cur_lvl == dmmp_pkg::LVL_AREA);
        end
    end

    property p_app_id;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        go |=> st_q == dmmp_pkg::ST_ID && emc_q == 7'h03 && em_q[95:93] == 3'b010;
    endproperty
    a_app_id: assert property (p_app_id) else $error("identifier not coded as one");

    property p_app_ver;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q == dmmp_pkg::ST_ID && fire && adv |=> st_q == dmmp_pkg::ST_VER && emc_q == 7'h01 && bit_o;
    endproperty
    a_app_ver: assert property (p_app_ver) else $error("version not coded as zero");

    property p_cnt_range;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q == dmmp_pkg::ST_CNT |-> cnt_q >= 8'h01 && cnt_q <= 8'hfe;
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("block count out of range");

    property p_first_aligned;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(st_q == dmmp_pkg::ST_LEN) && idx_q == 8'h00 |-> pos_q == 3'h0 &&
            $past(st_q) != dmmp_pkg::ST_AL1 || !$past(bit_o);
    endproperty
    a_first_aligned: assert property (p_first_aligned) else $error("first block not aligned");

    property p_lvl_width;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(st_q == dmmp_pkg::ST_LVL) |-> emc_q == 7'h08 ##0 $past(st_q) == dmmp_pkg::ST_LEN;
    endproperty
    a_lvl_width: assert property (p_lvl_width) else $error("level field not 8 bits");

    property p_no_reserved;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q == dmmp_pkg::ST_PAY |-> lvl_known(cur_lvl);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved level sent");

    property p_blk_len;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(st_q == dmmp_pkg::ST_PAY) |-> emc_q == (cur_lvl == 8'h01 ? 7'h28 :
                                               cur_lvl == 8'h02 ? 7'h58 : 7'h38);
    endproperty
    a_blk_len: assert property (p_blk_len) else $error("block byte length wrong");

    property p_area_order;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q == dmmp_pkg::ST_LVL && fire && adv && cur_lvl == dmmp_pkg::LVL_AREA |-> seen_q;
    endproperty
    a_area_order: assert property (p_area_order) else $error("area block not preceded");

    property p_tail_order;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        bit_last_o && bit_ready_i && any5_q |-> !seen_q;
    endproperty
    a_tail_order: assert property (p_tail_order) else $error("block after last area");

    property p_weight;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(st_q == dmmp_pkg::ST_PAY) && cur_lvl == dmmp_pkg::LVL_TRIM |->
            em_q[23:11] == 13'h1fff && em_q[10:8] == 3'h0;
    endproperty
    a_weight: assert property (p_weight) else $error("reserved weight not all ones");

endmodule : dmmp_producer
